// [logic/adc_rate_reference_config_regs.sv]
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

module adc_rate_reference_config_regs
	import adc_cfg_pkg::*;
#(
	parameter int SAMPLE_W = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Power-down pin
	input wire logic power_down,
	// Conversion control
	input wire logic conv_start,
	output logic conv_run,
	// Raw readings from the modulator, and its input swap control
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_data,
	output logic input_swap,
	// Finished results
	output logic result_valid,
	output logic [SAMPLE_W-1:0] result_data,
	// Analog control lines
	output analog_ctl_s analog_ctl
);

	////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchroniser

	logic rst_meta_r;
	logic rst_sync_r;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	logic [PIN_SYNC_STAGES-1:0] pd_sync_r;
	logic pd_r;
	// Only the last two stages are trusted, the first may be metastable
	wire pd_agree = pd_sync_r[1] == pd_sync_r[2];
	wire [PIN_SYNC_STAGES-1:0] pd_sync_nxt = {pd_sync_r[PIN_SYNC_STAGES-2:0], power_down};
	wire pd_nxt = pd_agree ? pd_sync_r[2] : pd_r;

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			pd_sync_r <= '0;
		end else begin
			pd_sync_r <= pd_sync_nxt;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			pd_r <= 1'b0;
		end else begin
			pd_r <= pd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register file

	logic [DATA_W-1:0] rate_cfg_r;
	logic [DATA_W-1:0] ref_ctl_r;
	logic [DATA_W-1:0] exc_mag_r;

	wire hit_rate = reg_addr == OFS_RATE_CFG;
	wire hit_ref = reg_addr == OFS_REF_CTL;
	wire hit_exc = reg_addr == OFS_EXC_MAG;
	wire wr_rate = reg_wr && hit_rate;
	wire wr_ref = reg_wr && hit_ref;
	wire wr_exc = reg_wr && hit_exc;

	// Writes to unmapped addresses change nothing
	wire [DATA_W-1:0] rate_cfg_nxt = wr_rate ? reg_wdata : rate_cfg_r;
	wire [DATA_W-1:0] ref_ctl_nxt = wr_ref ? reg_wdata : ref_ctl_r;
	// Bits 5:4 dropped at the write, so they always read zero
	wire [DATA_W-1:0] exc_mag_nxt = wr_exc ? (reg_wdata & EXC_MAG_WMASK) : exc_mag_r;

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			rate_cfg_r <= RATE_CFG_RST;
		end else begin
			rate_cfg_r <= rate_cfg_nxt;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			ref_ctl_r <= REF_CTL_RST;
		end else begin
			ref_ctl_r <= ref_ctl_nxt;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			exc_mag_r <= EXC_MAG_RST;
		end else begin
			exc_mag_r <= exc_mag_nxt;
		end
	end

	wire [DATA_W-1:0] read_mux =
		hit_rate ? rate_cfg_r :
		hit_ref ? ref_ctl_r :
		hit_exc ? exc_mag_r : '0;
	// Zero outside the one-cycle read slot
	wire [DATA_W-1:0] rdata_nxt = reg_rd ? read_mux : '0;
	logic [DATA_W-1:0] rdata_r;

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////
	// Field decode

	wire chop_on = rate_cfg_r[CHOP_BIT];
	wire single_shot = rate_cfg_r[CONV_MODE_BIT];
	wire [RATE_W-1:0] rate_code = rate_cfg_r[RATE_LSB +: RATE_W];
	ref_mon_e ref_mon;
	ref_sel_e ref_sel;
	ref_pwr_e ref_pwr;
	assign ref_mon = ref_mon_e'(ref_ctl_r[REF_MON_LSB +: 2]);
	assign ref_sel = ref_sel_e'(ref_ctl_r[REF_SEL_LSB +: 2]);
	assign ref_pwr = ref_pwr_e'(ref_ctl_r[REF_PWR_LSB +: 2]);

	// Rate in tenths of a sample per second, zero for unlisted codes
	function automatic logic [15:0] rate_deci(input logic [RATE_W-1:0] code);
		logic [15:0] r;
		r = 16'h0000;
		unique case (code)
			4'h0: r = 16'h0019;
			4'h1: r = 16'h0032;
			4'h2: r = 16'h0064;
			4'h3: r = 16'h00A6;
			4'h4: r = 16'h00C8;
			4'h5: r = 16'h01F4;
			4'h6: r = 16'h0258;
			4'h7: r = 16'h03E8;
			default: r = 16'h0000;
		endcase
		return r;
	endfunction

	wire ref_int_on = (ref_pwr == REF_PWR_ALWAYS)
		|| (ref_pwr == REF_PWR_ON_PD_OFF && !pd_r);
	// Current sources only run from a live internal reference
	wire [EXC_MAG_W-1:0] mag_eff =
		ref_int_on ? exc_mag_r[EXC_MAG_LSB +: EXC_MAG_W] : '0;

	analog_ctl_s ctl_nxt;

	always_comb begin
		ctl_nxt = '0;
		ctl_nxt.chop_en = chop_on;
		ctl_nxt.ext_clock_select = rate_cfg_r[CLK_SRC_BIT];
		ctl_nxt.single_shot = single_shot;
		ctl_nxt.low_latency_filter = rate_cfg_r[FILTER_BIT];
		ctl_nxt.output_rate_code = rate_code;
		ctl_nxt.rate_deci_sps = rate_deci(rate_code);
		ctl_nxt.reference_low_threshold_monitor = ref_mon != REF_MON_OFF;
		ctl_nxt.reference_third_span_monitor = ref_mon == REF_MON_LOW_THIRD;
		ctl_nxt.reference_pull_together = ref_mon == REF_MON_LOW_PULL;
		ctl_nxt.positive_reference_buffer_bypass = ref_ctl_r[REFP_BYP_BIT];
		ctl_nxt.negative_reference_buffer_bypass = ref_ctl_r[REFN_BYP_BIT];
		ctl_nxt.route_ref_pair0 = ref_sel == REF_SRC_PAIR0;
		ctl_nxt.route_ref_pair1 = ref_sel == REF_SRC_PAIR1;
		ctl_nxt.route_ref_internal = ref_sel == REF_SRC_INTERNAL;
		ctl_nxt.internal_reference_on = ref_int_on;
		ctl_nxt.excitation_magnitude = mag_eff;
		ctl_nxt.low_side_switch_close = exc_mag_r[LOW_SW_BIT] && !pd_r;
		ctl_nxt.amp_rail_monitor_en = exc_mag_r[RAIL_MON_BIT];
	end

	analog_ctl_s ctl_r;

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			ctl_r <= '0;
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	assign analog_ctl = ctl_r;

	////////////////////////////////////////////////////////////////////////////
	// Conversion run control

	logic run_r;
	logic result_valid_r;
	logic [SAMPLE_W-1:0] result_r;
	wire result_fire;

	// Single-shot stops after one result; continuous always runs
	wire run_nxt = single_shot ? ((run_r || conv_start) && !result_fire) : 1'b1;

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			run_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
		end
	end

	assign conv_run = run_r;

	////////////////////////////////////////////////////////////////////////////
	// Chop pairing and averaging

	chop_state_e chop_st_r;
	chop_state_e chop_st_nxt;
	logic swap_r;
	logic [SAMPLE_W-1:0] first_r;

	wire take = sample_valid && run_r;
	// Swapped reading is negated, so the average is half the difference
	wire signed [SAMPLE_W:0] diff = $signed({first_r[SAMPLE_W-1], first_r})
		- $signed({sample_data[SAMPLE_W-1], sample_data});
	wire [SAMPLE_W-1:0] chop_avg = diff[SAMPLE_W:1];
	wire pair_done = take && chop_st_r == CHOP_SECOND;
	assign result_fire = chop_on ? pair_done : take;

	always_comb begin
		chop_st_nxt = chop_st_r;
		unique case (chop_st_r)
			CHOP_IDLE: begin
				if (chop_on) begin
					chop_st_nxt = CHOP_FIRST;
				end
			end
			CHOP_FIRST: begin
				if (!chop_on) begin
					chop_st_nxt = CHOP_IDLE;
				end else if (take) begin
					chop_st_nxt = CHOP_SECOND;
				end
			end
			CHOP_SECOND: begin
				if (!chop_on) begin
					chop_st_nxt = CHOP_IDLE;
				end else if (take) begin
					chop_st_nxt = CHOP_FIRST;
				end
			end
			default: chop_st_nxt = CHOP_IDLE;
		endcase
	end

	// Swap is registered so the inputs turn before the next reading
	wire swap_nxt = (chop_st_nxt == CHOP_SECOND);
	wire take_first = take && chop_st_r == CHOP_FIRST;
	wire [SAMPLE_W-1:0] first_nxt = take_first ? sample_data : first_r;

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			chop_st_r <= CHOP_IDLE;
		end else begin
			chop_st_r <= chop_st_nxt;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			swap_r <= 1'b0;
		end else begin
			swap_r <= swap_nxt;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			first_r <= '0;
		end else begin
			first_r <= first_nxt;
		end
	end

	assign input_swap = swap_r;

	// A result holds until the next one replaces it
	wire [SAMPLE_W-1:0] result_nxt = chop_on ? chop_avg : sample_data;

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			result_valid_r <= 1'b0;
		end else begin
			result_valid_r <= result_fire;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			result_r <= '0;
		end else if (result_fire) begin
			result_r <= result_nxt;
		end
	end

	assign result_valid = result_valid_r;
	assign result_data = result_r;

endmodule

// [shared/adc_cfg_pkg.sv]
package adc_cfg_pkg;

	// Register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_RATE_CFG = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_REF_CTL = 8'h05;
	localparam logic [ADDR_W-1:0] OFS_EXC_MAG = 8'h06;

	// Values after reset
	localparam logic [DATA_W-1:0] RATE_CFG_RST = 8'h14;
	localparam logic [DATA_W-1:0] REF_CTL_RST = 8'h10;
	localparam logic [DATA_W-1:0] EXC_MAG_RST = 8'h00;

	// Writable bits of the excitation register, bits 5:4 read zero
	localparam logic [DATA_W-1:0] EXC_MAG_WMASK = 8'hCF;

	// Field positions, conversion rate and configuration
	localparam int CHOP_BIT = 7;
	localparam int CLK_SRC_BIT = 6;
	localparam int CONV_MODE_BIT = 5;
	localparam int FILTER_BIT = 4;
	localparam int RATE_LSB = 0;
	localparam int RATE_W = 4;

	// Field positions, reference control
	localparam int REF_MON_LSB = 6;
	localparam int REFP_BYP_BIT = 5;
	localparam int REFN_BYP_BIT = 4;
	localparam int REF_SEL_LSB = 2;
	localparam int REF_PWR_LSB = 0;

	// Field positions, excitation current
	localparam int RAIL_MON_BIT = 7;
	localparam int LOW_SW_BIT = 6;
	localparam int EXC_MAG_LSB = 0;
	localparam int EXC_MAG_W = 4;

	// Synchroniser depth for pin inputs
	localparam int PIN_SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		REF_MON_OFF = 2'h0,
		REF_MON_LOW = 2'h1,
		REF_MON_LOW_THIRD = 2'h2,
		REF_MON_LOW_PULL = 2'h3
	} ref_mon_e;

	typedef enum logic [1:0] {
		REF_SRC_PAIR0 = 2'h0,
		REF_SRC_PAIR1 = 2'h1,
		REF_SRC_INTERNAL = 2'h2,
		REF_SRC_RESERVED = 2'h3
	} ref_sel_e;

	typedef enum logic [1:0] {
		REF_PWR_OFF = 2'h0,
		REF_PWR_ON_PD_OFF = 2'h1,
		REF_PWR_ALWAYS = 2'h2,
		REF_PWR_RESERVED = 2'h3
	} ref_pwr_e;

	// Chop pairing states, Gray along the path
	typedef enum logic [1:0] {
		CHOP_IDLE = 2'b00,
		CHOP_FIRST = 2'b01,
		CHOP_SECOND = 2'b11
	} chop_state_e;

	// Control lines toward the analog circuits
	typedef struct packed {
		logic chop_en;
		logic ext_clock_select;
		logic single_shot;
		logic low_latency_filter;
		logic [RATE_W-1:0] output_rate_code;
		logic [15:0] rate_deci_sps;
		logic reference_low_threshold_monitor;
		logic reference_third_span_monitor;
		logic reference_pull_together;
		logic positive_reference_buffer_bypass;
		logic negative_reference_buffer_bypass;
		logic route_ref_pair0;
		logic route_ref_pair1;
		logic route_ref_internal;
		logic internal_reference_on;
		logic [EXC_MAG_W-1:0] excitation_magnitude;
		logic low_side_switch_close;
		logic amp_rail_monitor_en;
	} analog_ctl_s;

endpackage

// [verif/adc_rate_reference_config_regs_props.sv]
`timescale 1ns/1ps
module adc_rate_reference_config_regs_props
	import adc_cfg_pkg::*;
#(
	parameter int SAMPLE_W = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// Pins, samples, controls
	input wire logic power_down,
	input wire logic conv_start,
	input wire logic conv_run,
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_data,
	input wire logic input_swap,
	input wire logic result_valid,
	input wire logic [SAMPLE_W-1:0] result_data,
	input wire analog_ctl_s analog_ctl
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic [DATA_W-1:0] w1_r;
	logic [DATA_W-1:0] w2_r;
	wire wr_ref = reg_wr && reg_addr == OFS_REF_CTL;
	wire wr_exc = reg_wr && reg_addr == OFS_EXC_MAG;
	wire wr_rate = reg_wr && reg_addr == OFS_RATE_CFG;
	// Write data two cycles back, lines up with the control outputs
	always_ff @(posedge clock) begin
		w1_r <= reg_wdata;
		w2_r <= w1_r;
	end
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	a_excit_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == OFS_EXC_MAG |-> reg_rdata[5:4] == 2'h0)
		else $error("reserved excitation bits not zero");
	a_ref_monitors: assert property (wr_ref |-> ##2 analog_ctl.reference_low_threshold_monitor == (w2_r[7:6] != 2'h0)
		&& analog_ctl.reference_third_span_monitor == (w2_r[7:6] == 2'h2)
		&& analog_ctl.reference_pull_together == (w2_r[7:6] == 2'h3))
		else $error("reference monitor decode wrong");
	a_ref_buffers: assert property (wr_ref |-> ##2 analog_ctl.positive_reference_buffer_bypass == w2_r[5]
		&& analog_ctl.negative_reference_buffer_bypass == w2_r[4])
		else $error("buffer bypass wrong");
	a_ref_route: assert property (wr_ref |-> ##2 {analog_ctl.route_ref_internal, analog_ctl.route_ref_pair1,
		analog_ctl.route_ref_pair0} == (w2_r[3:2] == 2'h3 ? 3'h0 : 3'h1 << w2_r[3:2]))
		else $error("reference routing wrong");
	a_rate_fields: assert property (wr_rate |-> ##2 {analog_ctl.chop_en, analog_ctl.ext_clock_select,
		analog_ctl.single_shot, analog_ctl.low_latency_filter, analog_ctl.output_rate_code} == w2_r)
		else $error("rate fields wrong");
	a_exc_fields: assert property (wr_exc && !power_down |-> ##2 analog_ctl.amp_rail_monitor_en == w2_r[7]
		&& analog_ctl.low_side_switch_close == w2_r[6] && analog_ctl.excitation_magnitude
		== (analog_ctl.internal_reference_on ? w2_r[3:0] : 4'h0))
		else $error("excitation fields wrong");
	a_pd_switch_open: assert property (power_down [*6] |-> !analog_ctl.low_side_switch_close)
		else $error("switch closed in power-down");
	a_result_cause: assert property (result_valid |-> $past(sample_valid) && $past(conv_run))
		else $error("result without sample");
	a_chop_swap: assert property (analog_ctl.chop_en && sample_valid && conv_run && !input_swap
		&& !reg_wr && !$past(reg_wr) |=> input_swap && !result_valid)
		else $error("chop did not swap");
	a_plain_result: assert property (!analog_ctl.chop_en && sample_valid && conv_run && !$past(reg_wr)
		|=> result_valid && result_data == $past(sample_data))
		else $error("unchopped result wrong");
endmodule

bind adc_rate_reference_config_regs adc_rate_reference_config_regs_props #(.SAMPLE_W(SAMPLE_W)) u_props (
	.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_down(power_down), .conv_start(conv_start),
	.conv_run(conv_run), .sample_valid(sample_valid), .sample_data(sample_data),
	.input_swap(input_swap), .result_valid(result_valid), .result_data(result_data),
	.analog_ctl(analog_ctl));

// [verif/test_adc_rate_reference_config_regs.sv]
`timescale 1ns/1ps
module test_adc_rate_reference_config_regs
	import adc_cfg_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic power_down = 1'b0;
	logic conv_start = 1'b0;
	logic conv_run;
	logic sample_valid = 1'b0;
	logic [15:0] sample_data = 16'h0000;
	logic input_swap;
	logic result_valid;
	logic [15:0] result_data;
	analog_ctl_s analog_ctl;
	logic rd_d_r = 1'b0;
	logic [15:0] rd_q[$];
	logic [15:0] res_q[$];
	int mismatches = 0;
	int n_tests = 0;
	logic [15:0] a;
	logic [15:0] b;
	logic [16:0] df;
	logic [7:0] d;
	logic [7:0] rv;
	logic [15:0] rate_x10 [8] = '{16'h0019, 16'h0032, 16'h0064, 16'h00A6,
		16'h00C8, 16'h01F4, 16'h0258, 16'h03E8};

	adc_rate_reference_config_regs uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.power_down(power_down), .conv_start(conv_start), .conv_run(conv_run),
		.sample_valid(sample_valid), .sample_data(sample_data), .input_swap(input_swap),
		.result_valid(result_valid), .result_data(result_data), .analog_ctl(analog_ctl));

	always #50 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [7:0] dt);
		@(posedge clock);
		reg_addr <= ad;
		reg_wdata <= dt;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] ad, input logic [7:0] ex);
		rd_q.push_back({8'h00, ex});
		@(posedge clock);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask
	task samp(input logic [15:0] v);
		@(posedge clock);
		sample_data <= v;
		sample_valid <= 1'b1;
		@(posedge clock);
		sample_valid <= 1'b0;
	endtask
	task settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task pd(input logic v);
		@(posedge clock);
		power_down <= v;
		settle(8);
	endtask
	task summarize;
		$display("comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Output watcher, compares against the oldest note
	always @(posedge clock) rd_d_r <= reg_rd;
	always @(negedge clock) begin
		if (rd_d_r) begin
			chk({8'h00, reg_rdata}, rd_q.pop_front());
		end
		if (result_valid !== 1'b0) begin
			if (res_q.size() == 0) begin
				chk(16'h0001, 16'h0000);
			end else begin
				chk(result_data, res_q.pop_front());
			end
		end
	end

	initial begin
		#2000000;
		mismatches++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hA528));
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		settle(3);
		rd(8'h04, 8'h14);
		rd(8'h05, 8'h10);
		rd(8'h06, 8'h00);
		rd(8'h09, 8'h00);
		chk(analog_ctl.rate_deci_sps, 16'h00C8);
		chk({analog_ctl.low_latency_filter, analog_ctl.negative_reference_buffer_bypass}, 2'h3);
		// Every monitor, source and power code, random rest
		for (int i = 0; i < 16; i++) begin
			d = 8'($urandom);
			rv = {i[3:2], ((i[1:0] == 2'h2) ? 2'h3 : i[3:2]), i[1:0], ~i[1:0]};
			if (rv[1:0] != 2'h1 && rv[1:0] != 2'h2) begin
				d[3:0] = 4'h0;
			end
			wr(8'h05, rv);
			rd(8'h05, rv);
			wr(8'h06, d);
			rd(8'h06, d & 8'hCF);
			wr(8'h04, {i[1:0], d[5:0]});
			rd(8'h04, {i[1:0], d[5:0]});
			wr(8'h09, d);
			rd(8'h09, 8'h00);
		end
		for (int c = 0; c < 8; c++) begin
			wr(8'h04, 8'h10 | 8'(c));
			settle(2);
			chk(analog_ctl.rate_deci_sps, rate_x10[c]);
		end
		// Reference power against power-down
		wr(8'h05, 8'h02);
		wr(8'h06, 8'hC1);
		settle(2);
		chk({analog_ctl.excitation_magnitude, analog_ctl.low_side_switch_close}, 5'h03);
		pd(1'b1);
		chk({analog_ctl.internal_reference_on, analog_ctl.low_side_switch_close}, 2'h2);
		pd(1'b0);
		wr(8'h05, 8'h01);
		pd(1'b1);
		chk({analog_ctl.internal_reference_on, analog_ctl.excitation_magnitude}, 5'h00);
		pd(1'b0);
		// Chopped pairs, then one plain reading
		wr(8'h04, 8'h94);
		settle(2);
		for (int i = 0; i < 4; i++) begin
			a = 16'($urandom);
			b = 16'($urandom);
			df = {a[15], a} - {b[15], b};
			res_q.push_back(df[16:1]);
			samp(a);
			samp(b);
		end
		wr(8'h04, 8'h14);
		settle(2);
		res_q.push_back(a);
		samp(a);
		// Single shot: running conversion ends, a start pulse runs one more
		wr(8'h04, 8'h34);
		settle(2);
		res_q.push_back(b);
		samp(b);
		settle(2);
		chk(conv_run, 1'b0);
		samp(a);
		@(posedge clock);
		conv_start <= 1'b1;
		@(posedge clock);
		conv_start <= 1'b0;
		settle(2);
		chk(conv_run, 1'b1);
		res_q.push_back(a);
		samp(a);
		settle(2);
		chk(conv_run, 1'b0);
		samp(b);
		settle(3);
		chk(16'(res_q.size()), 16'h0000);
		summarize();
	end
endmodule
